// >>> pdsp_defines.vh
`ifndef PDSP_DEFINES_VH
`define PDSP_DEFINES_VH
// Packet layout
`define PDSP_PKT_BITS      32
`define PDSP_ID_BITS       8
`define PDSP_INFO_BITS     24
// Packet identifiers
`define PDSP_ID_CHECKSUM   8'h00
`define PDSP_ID_SPECIAL_LO 8'h1C
`define PDSP_ID_SPECIAL_HI 8'h1F
`define PDSP_ID_STATUS     8'h7F
`define PDSP_ID_PART       8'hFF
// Clock dividers on the reference
`define PDSP_DIV4_HALF     2
`define PDSP_FRAC_NUM      12
`define PDSP_FRAC_DEN      25
// Minute timer, reference ticks per minute
`define PDSP_INT_REF_HZ    160000
`define PDSP_EXT_REF_HZ    76800
`define PDSP_SEC_PER_MIN   60
// Receiver control stage counts
`define PDSP_RX_STAGES_INT 7
`define PDSP_RX_STAGES_EXT 8
`endif

// >>> pdsp_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module pdsp_host_model (
    input wire logic  clk_in,
    input wire logic  ready_n_in,
    input wire logic  miso_in,
    output var logic  ss_n_out,
    output var logic  sck_out,
    output var logic  mosi_out
);
    // Idle: deselected, clock standing low
    initial begin
        ss_n_out = 1'b1;
        sck_out = 1'b0;
        mosi_out = 1'b0;
    end
    // One full-duplex exchange, MSB first, select kept low when keep is set
    task automatic xfer(input logic [31:0] tx, input logic keep, output logic [31:0] rx);
        int w;
        repeat (2) @(posedge clk_in);
        #5 ss_n_out = 1'b0;
        w = 0;
        while (ready_n_in !== 1'b0 && w < 200) begin
            @(posedge clk_in);
            #5 w++;
        end
        for (int n = 31; n >= 0; n--) begin
            mosi_out = tx[n];
            repeat (3) @(posedge clk_in);
            #5 sck_out = 1'b1;
            rx[n] = miso_in;
            repeat (3) @(posedge clk_in);
            #5 sck_out = 1'b0;
        end
        repeat (3) @(posedge clk_in);
        #5 mosi_out = ~mosi_out; // Released line shows no stale bit
        if (!keep) ss_n_out = 1'b1;
    endtask
endmodule // pdsp_host_model
`default_nettype wire

// >>> pdsp_packet_port.v
`timescale 1ns/10ps
`default_nettype none
`include "pdsp_defines.vh"

// Contract
// - Each packet is 32 bits: 8-bit identifier then 24 information bits.
// - Full duplex: both directions carry a valid packet every exchange.
// - Host drives serial clock and MOSI, select is chip select; MISO answers.
// - Once selected, the decoder lowers ready to let the shift proceed.
// - Each host-started packet needs a fresh falling edge of select.
// - Enabled decoder with nothing pending returns a status packet.
// - Decoder with a packet lowers ready; host selects and exchanges 32 bits.
// - Decoder-started packets may follow back to back with select held low.
// - Internal demodulator: 160 kHz reference, output 38.4 or 40 kHz.
// - External demodulator: 76.8 kHz reference, output 38.4 kHz when enabled.
// - Seven receiver control outputs internal, eight external.
// - A one-minute timer gives the host a time-of-day base.
// - Packets shift most significant bit first; bit 31 first.
// - Reset disables sending and loads checksum with the part identifier.
// - Ordinary packets fold into checksum and disable; matching checksum enables.
module pdsp_packet_port #(
    parameter [23:0] PART_ID   = 24'h5A5A5A, // Arbitrary neutral value
    // Reference ticks per minute for the internal and the external demodulator
    parameter        MIN_TICKS     = `PDSP_INT_REF_HZ * `PDSP_SEC_PER_MIN,
    parameter        MIN_TICKS_EXT = `PDSP_EXT_REF_HZ * `PDSP_SEC_PER_MIN
) (
    input  wire        sys_clk_in,
    input  wire        rst_n_in,
    input  wire        ss_n_in,
    input  wire        sck_in,
    input  wire        mosi_in,
    input  wire        ref_tick_in,
    input  wire        ext_demod_in,
    input  wire        clk_out_en_in,
    input  wire        clk_sel_div4_in,
    input  wire        tx_valid_in,
    input  wire [31:0] tx_data_in,
    input  wire [7:0]  rx_stage_in,
    output reg         miso_out,
    output reg         ready_n_out,
    output reg         tx_taken_out,
    output reg         rx_valid_out,
    output reg  [31:0] rx_data_out,
    output reg         enabled_out,
    output reg         divided_clock_output,
    output reg         minute_tick_out,
    output reg  [7:0]  rx_ctrl_out
);
    // Exchange states: wait for a start, shift 32 bits, report the packet
    localparam ST_IDLE  = 2'd0;
    localparam ST_SHIFT = 2'd1;
    localparam ST_DONE  = 2'd2;

    // Exchange state, select and clock history, shifters and checksum
    reg  [1:0]  state;
    reg         ss_q;
    reg         sck_q;
    reg         armed;
    reg  [31:0] tx_sh;
    reg  [31:0] rx_sh;
    reg  [5:0]  bit_cnt;
    reg  [23:0] checksum_value_field;
    reg         from_dev;
    // Clock output dividers and minute counter
    reg  [4:0]  frac_acc;
    reg  [1:0]  div_cnt;
    reg  [31:0] min_cnt;

    // Edge detection on the sampled select and serial clock
    wire        ss_fall = ss_q & ~ss_n_in;
    wire        sck_rise = ~sck_q & sck_in;
    wire        sck_fall = sck_q & ~sck_in;
    wire [7:0]  rx_id = rx_sh[31:24];
    wire        is_special = (rx_id >= `PDSP_ID_SPECIAL_LO) && (rx_id <= `PDSP_ID_SPECIAL_HI);
    wire        dev_pend = tx_valid_in & enabled_out;
    wire [31:0] status_pkt = {`PDSP_ID_STATUS, 24'h000000};
    wire [31:0] part_pkt = {`PDSP_ID_PART, PART_ID};
    // Fractional divider sum is one bit wider so that 24 + 12 cannot wrap
    wire [5:0]  frac_sum = {1'b0, frac_acc} + 6'h0C;
    wire [5:0]  frac_wrap = frac_sum - 6'h19;
    // Minute length follows the reference selected by the demodulator choice
    wire [31:0] min_limit = ext_demod_in ? MIN_TICKS_EXT : MIN_TICKS;

    // Edge history of select and serial clock
    always @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ss_q  <= 1'b1;
            sck_q <= 1'b0;
        end else begin
            ss_q  <= ss_n_in;
            sck_q <= sck_in;
        end
    end

    // Packet exchange state machine
    always @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state                <= ST_IDLE;
            armed                <= 1'b0;
            tx_sh                <= 32'h00000000;
            rx_sh                <= 32'h00000000;
            bit_cnt              <= 6'h00;
            miso_out             <= 1'b0;
            ready_n_out          <= 1'b1;
            tx_taken_out         <= 1'b0;
            rx_valid_out         <= 1'b0;
            rx_data_out          <= 32'h00000000;
            enabled_out          <= 1'b0;
            checksum_value_field <= PART_ID;
            from_dev             <= 1'b0;
        end else begin
            tx_taken_out <= 1'b0;
            rx_valid_out <= 1'b0;
            // Remember a select fall seen outside the shift state; a fall that merely selects
            // the decoder for its own pending packet must not start a host packet
            if (ss_fall && state != ST_SHIFT)
                armed <= 1'b1;
            case (state)
                ST_IDLE: begin
                    // Decoder-started when a packet waits, else on fresh select
                    if (dev_pend || (armed && !ss_n_in) || (ss_fall)) begin
                        if (dev_pend) begin
                            tx_sh        <= tx_data_in;
                            tx_taken_out <= 1'b1;
                        end else if (enabled_out)
                            tx_sh <= status_pkt;
                        else
                            tx_sh <= part_pkt;
                        from_dev    <= dev_pend;
                        armed       <= 1'b0;
                        bit_cnt     <= 6'h00;
                        ready_n_out <= 1'b0;
                        state       <= ST_SHIFT;
                    end
                end
                ST_SHIFT: begin
                    // A host packet cut short by deselection is dropped
                    if (ss_n_in && !from_dev) begin
                        ready_n_out <= 1'b1;
                        state       <= ST_IDLE;
                    end else if (!ss_n_in) begin
                        miso_out <= tx_sh[31];
                        if (sck_rise) begin
                            rx_sh   <= {rx_sh[30:0], mosi_in};
                            bit_cnt <= bit_cnt + 6'h01;
                        end
                        // Next MISO bit on the falling edge; bit 31 stands before the first rise
                        if (sck_fall && bit_cnt != 6'h00)
                            tx_sh <= {tx_sh[30:0], 1'b0};
                        // All 32 bits in: release ready and report the packet
                        if (bit_cnt == 6'd32) begin
                            ready_n_out <= 1'b1;
                            state       <= ST_DONE;
                        end
                    end
                end
                ST_DONE: begin
                    // Hand the received packet on for one cycle
                    rx_valid_out <= 1'b1;
                    rx_data_out  <= rx_sh;
                    from_dev     <= 1'b0;
                    state        <= ST_IDLE;
                    // Checksum bookkeeping on the received packet
                    if (rx_id == `PDSP_ID_CHECKSUM) begin
                        if (!enabled_out && rx_sh[23:0] == checksum_value_field)
                            enabled_out <= 1'b1;
                    end else if (!is_special) begin
                        checksum_value_field <= checksum_value_field ^ rx_sh[23:0];
                        enabled_out          <= 1'b0;
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // Clock output: toggle on 12 of every 25 reference ticks for 38.4 kHz,
    // on every second tick for 40 kHz, or on every tick of the external reference
    always @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            frac_acc             <= 5'h00;
            div_cnt              <= 2'h0;
            divided_clock_output <= 1'b0;
        end else if (!clk_out_en_in) begin
            divided_clock_output <= 1'b0;
        end else if (ref_tick_in) begin
            if (clk_sel_div4_in && !ext_demod_in) begin
                div_cnt <= div_cnt + 2'h1;
                if (div_cnt == 2'd1 || div_cnt == 2'd3)
                    divided_clock_output <= ~divided_clock_output;
            end else if (ext_demod_in) begin
                divided_clock_output <= ~divided_clock_output;
            end else if (frac_sum >= 6'h19) begin
                frac_acc             <= frac_wrap[4:0];
                divided_clock_output <= ~divided_clock_output;
            end else begin
                frac_acc <= frac_sum[4:0];
            end
        end
    end

    // Minute timer and receiver stage outputs
    always @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            min_cnt         <= 32'h00000000;
            minute_tick_out <= 1'b0;
            rx_ctrl_out     <= 8'h00;
        end else begin
            minute_tick_out <= 1'b0;
            // The eighth control line is held off with the internal demodulator
            rx_ctrl_out     <= ext_demod_in ? rx_stage_in : {1'b0, rx_stage_in[6:0]};
            if (ref_tick_in) begin
                if (min_cnt >= min_limit - 32'h00000001) begin
                    min_cnt         <= 32'h00000000;
                    minute_tick_out <= 1'b1;
                end else
                    min_cnt <= min_cnt + 32'h00000001;
            end
        end
    end
endmodule // pdsp_packet_port
`default_nettype wire

// >>> pdsp_port_asserts.sv
`timescale 1ns/10ps
`default_nettype none
module pdsp_port_asserts (
    input wire logic        sys_clk_in,
    input wire logic        rst_n_in,
    input wire logic        ss_n_in,
    input wire logic        tx_valid_in,
    input wire logic        ext_demod_in,
    input wire logic        ready_n_out,
    input wire logic        rx_valid_out,
    input wire logic [31:0] rx_data_out,
    input wire logic        enabled_out,
    input wire logic        tx_taken_out,
    input wire logic [7:0]  rx_ctrl_out
);
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!rst_n_in);
    // Handshake, enable and stage output relations
    property p_sel_ready; $fell(ss_n_in) && ready_n_out |-> ##[1:3] !ready_n_out; endproperty
    a_sel_ready: assert property (p_sel_ready) else $error("ready not lowered after select");
    property p_reset_off; $rose(rst_n_in) |-> !enabled_out; endproperty
    a_reset_off: assert property (p_reset_off) else $error("enabled after reset");
    property p_fold; rx_valid_out && rx_data_out[31:24] != 8'h00 && rx_data_out[31:26] != 6'h07
        |-> ##[0:2] !enabled_out; endproperty
    a_fold: assert property (p_fold) else $error("ordinary packet left port enabled");
    property p_pend; enabled_out && tx_valid_in && ss_n_in && ready_n_out |-> ##[1:8] !ready_n_out; endproperty
    a_pend: assert property (p_pend) else $error("pending packet not signalled");
    property p_taken; tx_taken_out |-> enabled_out; endproperty
    a_taken: assert property (p_taken) else $error("packet taken while disabled");
    property p_rx_pulse; rx_valid_out |=> !rx_valid_out; endproperty
    a_rx_pulse: assert property (p_rx_pulse) else $error("receive strobe too long");
    property p_ctrl_int; !ext_demod_in && !$past(ext_demod_in) && !$past(ext_demod_in, 2) |-> !rx_ctrl_out[7];
    endproperty
    a_ctrl_int: assert property (p_ctrl_int) else $error("eighth stage active in internal mode");
    property p_idle_high; ss_n_in && $past(ss_n_in) && !tx_valid_in && !$past(tx_valid_in) && enabled_out
        |-> ready_n_out; endproperty
    a_idle_high: assert property (p_idle_high) else $error("ready low while idle");
    c_taken: cover property (tx_taken_out);
    c_cksum: cover property (rx_valid_out && rx_data_out[31:24] == 8'h00);
    c_enable: cover property ($rose(enabled_out));
endmodule // pdsp_port_asserts
`default_nettype wire

// >>> tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    localparam logic [23:0] PID = 24'h3C6A91; // Arbitrary value
    logic        sys_clk_in = 1'b0, rst_n_in = 1'b0, ref_tick_in = 1'b0, ext_demod_in = 1'b0;
    logic        clk_out_en_in = 1'b1, clk_sel_div4_in = 1'b1, tx_valid_in = 1'b0, div_q = 1'b0;
    logic [31:0] tx_data_in = 32'h0, got, last_rx;
    logic [7:0]  rx_stage_in = 8'hFF;
    wire         ss_n, sck, mosi, miso, ready_n, tx_taken, rx_valid, enabled, div_clk, minute;
    wire  [31:0] rx_data;
    wire  [7:0]  rx_ctrl;
    int          failures = 0, checks = 0, edges = 0, minutes = 0, tick_cnt = 0;
    pdsp_packet_port #(.PART_ID(PID), .MIN_TICKS(10), .MIN_TICKS_EXT(5)) pdsp_packet_port_inst (
        .sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .ss_n_in(ss_n), .sck_in(sck), .mosi_in(mosi),
        .ref_tick_in(ref_tick_in),
        .ext_demod_in(ext_demod_in), .clk_out_en_in(clk_out_en_in), .clk_sel_div4_in(clk_sel_div4_in),
        .tx_valid_in(tx_valid_in), .tx_data_in(tx_data_in), .rx_stage_in(rx_stage_in), .miso_out(miso),
        .ready_n_out(ready_n), .tx_taken_out(tx_taken), .rx_valid_out(rx_valid), .rx_data_out(rx_data),
        .enabled_out(enabled), .divided_clock_output(div_clk), .minute_tick_out(minute), .rx_ctrl_out(rx_ctrl));
    pdsp_host_model pdsp_host_model_inst (.clk_in(sys_clk_in), .ready_n_in(ready_n), .miso_in(miso),
        .ss_n_out(ss_n), .sck_out(sck), .mosi_out(mosi));
    always #50 sys_clk_in = ~sys_clk_in;
    // Reference tick every fifth cycle; edge, minute and packet monitors
    always @(posedge sys_clk_in) begin
        tick_cnt <= (tick_cnt == 4) ? 0 : tick_cnt + 1;
        ref_tick_in <= #5 (tick_cnt == 4);
        div_q <= div_clk;
        if (div_clk === 1'b1 && div_q === 1'b0) edges <= edges + 1;
        if (minute === 1'b1) minutes <= minutes + 1;
        if (rx_valid === 1'b1) last_rx <= rx_data;
    end
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic hx(input logic [31:0] tx, input logic keep);
        pdsp_host_model_inst.xfer(tx, keep, got);
        repeat (4) @(posedge sys_clk_in);
        #5;
    endtask
    task automatic t_enable;
        chk("enabled after reset", enabled, 0);
        hx({8'h00, PID}, 1'b0);
        chk("part id answer", got[31:24], 8'hFF);
        chk("packet received", last_rx, {8'h00, PID});
        chk("checksum enables", enabled, 1);
        $display("t_enable done");
    endtask
    task automatic t_fold;
        hx({8'h1C, 24'hABCDEF}, 1'b0);
        chk("status answer", got[31:24], 8'h7F);
        chk("special keeps enable", enabled, 1);
        hx({8'h01, 24'h123456}, 1'b0);
        chk("ordinary disables", enabled, 0);
        hx({8'h00, PID}, 1'b0);
        chk("stale checksum refused", enabled, 0);
        hx({8'h00, PID ^ 24'h123456}, 1'b0);
        chk("folded checksum", enabled, 1);
        $display("t_fold done");
    endtask
    task automatic t_decoder;
        tx_data_in = 32'h01A5C3F0;
        tx_valid_in = 1'b1;
        fork
            begin
                wait (tx_taken === 1'b1);
                @(posedge sys_clk_in);
                #5 tx_data_in = 32'h025A3C0F;
                wait (tx_taken === 1'b1);
                @(posedge sys_clk_in);
                #5 tx_valid_in = 1'b0;
            end
            begin
                repeat (10) @(posedge sys_clk_in);
                #5 chk("ready for pending", ready_n, 0);
                hx(32'h0, 1'b1);
                chk("first decoder packet", got, 32'h01A5C3F0);
                hx(32'h0, 1'b0);
                chk("back to back packet", got, 32'h025A3C0F);
            end
        join
        chk("zero checksum keeps enable", enabled, 1);
        $display("t_decoder done");
    endtask
    task automatic t_clocks;
        logic [2:0] mode [4] = '{3'h3, 3'h2, 3'h6, 3'h4};
        int         exp_e [4] = '{25, 24, 50, 0};
        int         exp_m [4] = '{10, 10, 20, 20};
        int         e0, m0;
        for (int m = 0; m < 4; m++) begin
            {ext_demod_in, clk_out_en_in, clk_sel_div4_in} = mode[m];
            repeat (50) @(posedge sys_clk_in);
            #5 e0 = edges;
            m0 = minutes;
            repeat (500) @(posedge sys_clk_in);
            #5 chk("clock out edges", edges - e0 >= exp_e[m] - 1 && edges - e0 <= exp_e[m] + 1, 1);
            chk("minute ticks", minutes - m0 >= exp_m[m] - 1 && minutes - m0 <= exp_m[m] + 1, 1);
            chk("stage outputs", rx_ctrl, mode[m][2] ? 8'hFF : 8'h7F);
        end
        $display("t_clocks done");
    endtask
    task automatic close_out;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // Main sequence after six reset cycles
    initial begin
        repeat (6) @(posedge sys_clk_in);
        #5 rst_n_in = 1'b1;
        repeat (2) @(posedge sys_clk_in);
        t_enable;
        t_fold;
        t_decoder;
        t_clocks;
        close_out;
    end
    // Watchdog well beyond the expected run
    initial begin
        repeat (20000) @(posedge sys_clk_in);
        failures++;
        close_out;
    end
endmodule // tb_top
bind pdsp_packet_port pdsp_port_asserts pdsp_port_asserts_inst (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in),
    .ss_n_in(ss_n_in), .tx_valid_in(tx_valid_in), .ext_demod_in(ext_demod_in), .ready_n_out(ready_n_out),
    .rx_valid_out(rx_valid_out), .rx_data_out(rx_data_out), .enabled_out(enabled_out),
    .tx_taken_out(tx_taken_out), .rx_ctrl_out(rx_ctrl_out));
`default_nettype wire
